// ### src/smg_cfg.svh
`ifndef SMG_CFG_SVH
`define SMG_CFG_SVH
`define SMG_MODE_IDLE 3'h0
`define SMG_MODE_STANDBY 3'h1
`define SMG_MODE_POWER_DOWN 3'h2
`define SMG_WAKE_CYCLES 4'h6
`define SMG_STARTUP_NS 1000
`define SMG_CLK_NS 5
`define SMG_STARTUP_CYCLES ((`SMG_STARTUP_NS + `SMG_CLK_NS - 1) / `SMG_CLK_NS)
`define SMG_FILT_ASYNC 2'h0
`define SMG_EDGE_ASYNC 1'h0
`define SMG_NPER 8
`endif

// ### src/smg_pkg.sv
package smg_pkg;
   typedef enum logic [4:0] {
      SMG_ACTIVE = 5'b0_0001,
      SMG_DRAIN = 5'b0_0010,
      SMG_SLEEP = 5'b0_0100,
      SMG_START = 5'b0_1000,
      SMG_RESUME = 5'b1_0000
   } smg_state_t;
   typedef enum logic [2:0] {
      SMG_IDLE = 3'h0,
      SMG_STANDBY = 3'h1,
      SMG_POWER_DOWN = 3'h2
   } smg_mode_t;
endpackage : smg_pkg

// ### src/smg_wake_if.sv
`timescale 1ns/10ps
`default_nettype none
interface smg_wake_if;
   logic inIdle;
   logic inStandby;
   logic inPdown;
   logic hotLowLeak;
   logic wakeReq;
   modport ctl (output inIdle, output inStandby, output inPdown,
      output hotLowLeak, input wakeReq);
   modport dec (input inIdle, input inStandby, input inPdown,
      input hotLowLeak, output wakeReq);
endinterface : smg_wake_if
`default_nettype wire

// ### src/smg_wake_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "smg_cfg.svh"
module smg_wake_decode
   import smg_pkg::*;
(
   smg_wake_if.dec wk,
   input wire logic pinIrq,
   input wire logic vlmIrq,
   input wire logic mvioIrq,
   input wire logic pitIrq,
   input wire logic rtcCntIrq,
   input wire logic rtcRunStby,
   input wire logic twiMatchIrq,
   input wire logic cclIrq,
   input wire logic [1:0] cclFilterSelect,
   input wire logic cclEdgeDetect,
   input wire logic cclRunStby,
   input wire logic sofIrq,
   input wire logic [`SMG_NPER-1:0] perIrq,
   input wire logic [`SMG_NPER-1:0] perRunStby,
   input wire logic otherIrq
);
   logic cclAsync;
   logic [`SMG_NPER-1:0] perWake;
   logic anyWake;
   // Synchronous lookup paths need a running clock to see the edge
   assign cclAsync = (cclFilterSelect == `SMG_FILT_ASYNC) &&
      (cclEdgeDetect == `SMG_EDGE_ASYNC);
   genvar i;
   generate
      for (i = 0; i < `SMG_NPER; i++) begin : g_per
         assign perWake[i] = perIrq[i] &&
            (wk.inIdle || (wk.inStandby && perRunStby[i]));
      end
   endgenerate
   always_comb begin
      anyWake = pinIrq || vlmIrq || mvioIrq || pitIrq;
      anyWake = anyWake || (|perWake);
      if (wk.inIdle) begin
         anyWake = anyWake || otherIrq || rtcCntIrq;
      end
      if (wk.inStandby && rtcRunStby) begin
         anyWake = anyWake || rtcCntIrq;
      end
      if (twiMatchIrq && !(wk.inPdown && wk.hotLowLeak)) begin
         anyWake = 1'b1;
      end
      if (cclIrq && cclAsync && (wk.inIdle ||
         (wk.inStandby && cclRunStby) ||
         (wk.inPdown && !wk.hotLowLeak))) begin
         anyWake = 1'b1;
      end
      if (sofIrq && (wk.inIdle || wk.inStandby)) begin
         anyWake = 1'b1;
      end
   end
   assign wk.wakeReq = anyWake;
endmodule : smg_wake_decode
`default_nettype wire

// ### src/smg_sleep_gate.sv
`timescale 1ns/10ps
`default_nettype none
`include "smg_cfg.svh"
module smg_sleep_gate
   import smg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] sleepModeSelect,
   input wire logic sleepEnableBit,
   input wire logic hotLowLeakEnable,
   input wire logic sleepInstr,
   input wire logic nvmBusy,
   input wire logic pinIrq,
   input wire logic vlmIrq,
   input wire logic mvioIrq,
   input wire logic pitIrq,
   input wire logic rtcCntIrq,
   input wire logic twiMatchIrq,
   input wire logic cclIrq,
   input wire logic [1:0] cclFilterSelect,
   input wire logic cclEdgeDetect,
   input wire logic sofIrq,
   input wire logic [`SMG_NPER-1:0] perIrq,
   input wire logic [`SMG_NPER-1:0] perRunStby,
   input wire logic otherIrq,
   input wire logic mainClkRunStby,
   input wire logic rtcRunStby,
   input wire logic cclRunStby,
   output logic cpuHalt,
   output logic cpuResume,
   output logic sleeping,
   output logic [2:0] activeMode,
   output logic nvmDisable,
   output logic mainClkRun,
   output logic rtcClkRun,
   output logic rtcCounterRun,
   output logic pitRun,
   output logic cclClkRun,
   output logic tcdClkRun,
   output logic watchdogClkRun,
   output logic brownoutClkRun,
   output logic otherPerRun,
   output logic [`SMG_NPER-1:0] perRun
);
   localparam int STARTUP = `SMG_STARTUP_CYCLES;
   localparam logic [3:0] WAKE_N = `SMG_WAKE_CYCLES;
   typedef struct packed {
      smg_state_t st;
      logic [2:0] mode;
      logic hot;
      logic [9:0] cnt;
      logic halt;
      logic nvmOff;
   } smg_regs_t;
   smg_regs_t r_q;
   smg_regs_t r_d;
   smg_wake_if wk ();
   logic [2:0] pinSync1;
   logic [2:0] pinSync2;
   logic asleep;
   logic reqOk;
   assign asleep = (r_q.st == SMG_SLEEP) || (r_q.st == SMG_DRAIN);
   assign wk.inIdle = asleep && (r_q.mode == `SMG_MODE_IDLE);
   assign wk.inStandby = asleep && (r_q.mode == `SMG_MODE_STANDBY);
   assign wk.inPdown = asleep && (r_q.mode == `SMG_MODE_POWER_DOWN);
   assign wk.hotLowLeak = r_q.hot;
   // Pin-level wake sources are asynchronous to sys_clk
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSync1 <= 3'h0;
         pinSync2 <= 3'h0;
      end else begin
         pinSync1 <= {pinIrq, vlmIrq, mvioIrq};
         pinSync2 <= pinSync1;
      end
   end
   smg_wake_decode u_dec (
      .wk(wk.dec),
      .pinIrq(pinSync2[2]),
      .vlmIrq(pinSync2[1]),
      .mvioIrq(pinSync2[0]),
      .pitIrq(pitIrq),
      .rtcCntIrq(rtcCntIrq),
      .rtcRunStby(rtcRunStby),
      .twiMatchIrq(twiMatchIrq),
      .cclIrq(cclIrq),
      .cclFilterSelect(cclFilterSelect),
      .cclEdgeDetect(cclEdgeDetect),
      .cclRunStby(cclRunStby),
      .sofIrq(sofIrq),
      .perIrq(perIrq),
      .perRunStby(perRunStby),
      .otherIrq(otherIrq)
   );
   // Reserved codes are refused; core just keeps running
   assign reqOk = sleepInstr && sleepEnableBit &&
      (sleepModeSelect == `SMG_MODE_IDLE ||
       sleepModeSelect == `SMG_MODE_STANDBY ||
       sleepModeSelect == `SMG_MODE_POWER_DOWN);
   always_comb begin
      r_d = r_q;
      unique case (r_q.st)
         SMG_ACTIVE: begin
            if (reqOk) begin
               r_d.mode = sleepModeSelect;
               r_d.hot = hotLowLeakEnable;
               r_d.halt = 1'b1;
               r_d.st = SMG_DRAIN;
            end
         end
         SMG_DRAIN: begin
            if (wk.wakeReq) begin
               r_d.st = SMG_RESUME;
               r_d.cnt = 10'(WAKE_N);
            end else if (!nvmBusy) begin
               r_d.nvmOff = 1'b1;
               r_d.st = SMG_SLEEP;
            end
         end
         SMG_SLEEP: begin
            if (wk.wakeReq) begin
               r_d.nvmOff = 1'b0;
               if (r_q.mode == `SMG_MODE_IDLE) begin
                  r_d.st = SMG_RESUME;
                  r_d.cnt = 10'(WAKE_N);
               end else begin
                  r_d.st = SMG_START;
                  r_d.cnt = 10'(STARTUP);
               end
            end
         end
         SMG_START: begin
            if (r_q.cnt <= 10'h001) begin
               r_d.st = SMG_RESUME;
               r_d.cnt = 10'(WAKE_N);
            end else begin
               r_d.cnt = r_q.cnt - 10'h001;
            end
         end
         SMG_RESUME: begin
            if (r_q.cnt <= 10'h001) begin
               r_d.halt = 1'b0;
               r_d.nvmOff = 1'b0;
               r_d.st = SMG_ACTIVE;
               r_d.cnt = 10'h000;
            end else begin
               r_d.cnt = r_q.cnt - 10'h001;
            end
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_q <= '{st: SMG_ACTIVE, mode: 3'h0, hot: 1'b0, cnt: 10'h000,
            halt: 1'b0, nvmOff: 1'b0};
      end else begin
         r_q <= r_d;
      end
   end
   logic sb;
   logic pd;
   logic idl;
   assign sb = wk.inStandby || (r_q.st == SMG_START &&
      r_q.mode == `SMG_MODE_STANDBY);
   assign pd = wk.inPdown || (r_q.st == SMG_START &&
      r_q.mode == `SMG_MODE_POWER_DOWN);
   assign idl = !sb && !pd;
   assign cpuHalt = r_q.halt;
   assign cpuResume = (r_q.st == SMG_RESUME) && (r_q.cnt <= 10'h001);
   assign sleeping = asleep;
   assign activeMode = r_q.mode;
   assign nvmDisable = r_q.nvmOff;
   assign mainClkRun = idl || (sb && mainClkRunStby);
   assign rtcClkRun = idl || (sb && rtcRunStby) || pd;
   assign rtcCounterRun = idl || (sb && rtcRunStby);
   assign pitRun = 1'b1;
   assign cclClkRun = idl || (sb && cclRunStby);
   assign tcdClkRun = idl;
   assign watchdogClkRun = 1'b1;
   // Kept on always; only needed when detector samples
   assign brownoutClkRun = 1'b1;
   assign otherPerRun = idl;
   genvar g;
   generate
      for (g = 0; g < `SMG_NPER; g++) begin : g_run
         assign perRun[g] = idl || (sb && perRunStby[g]);
      end
   endgenerate

   property p_enter;
      @(posedge sys_clk) disable iff (!rst_n)
      (r_q.st == SMG_ACTIVE && reqOk) |=> cpuHalt;
   endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered");
   property p_noenter;
      @(posedge sys_clk) disable iff (!rst_n)
      (r_q.st == SMG_ACTIVE && !sleepEnableBit) |=> !cpuHalt;
   endproperty
   a_noenter: assert property (p_noenter) else $error("slept w/o enable");
   property p_nvm;
      @(posedge sys_clk) disable iff (!rst_n)
      nvmBusy |-> !nvmDisable || $past(!nvmBusy);
   endproperty
   a_nvm: assert property (p_nvm) else $error("nvm cut while busy");
   property p_wdt;
      @(posedge sys_clk) disable iff (!rst_n)
      sleeping |-> watchdogClkRun && brownoutClkRun;
   endproperty
   a_wdt: assert property (p_wdt) else $error("wdt clock stopped");
   property p_pd;
      @(posedge sys_clk) disable iff (!rst_n)
      wk.inPdown |-> !mainClkRun && !cclClkRun && !tcdClkRun;
   endproperty
   a_pd: assert property (p_pd) else $error("clock in powerdown");
   property p_sb;
      @(posedge sys_clk) disable iff (!rst_n)
      wk.inStandby && !perRunStby[0] |-> !perRun[0];
   endproperty
   a_sb: assert property (p_sb) else $error("peripheral ran");
   property p_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      wk.inIdle |-> otherPerRun && mainClkRun;
   endproperty
   a_idle: assert property (p_idle) else $error("idle stopped clock");
   sequence s_idleWake;
      r_q.st == SMG_SLEEP && wk.inIdle && wk.wakeReq;
   endsequence
   property p_wake;
      @(posedge sys_clk) disable iff (!rst_n)
      s_idleWake |-> ##7 !cpuHalt;
   endproperty
   a_wake: assert property (p_wake) else $error("wake time wrong");
   property p_sof;
      @(posedge sys_clk) disable iff (!rst_n)
      (r_q.st == SMG_SLEEP && wk.inPdown && !pinSync2[2] && !pinSync2[1]
       && !pinSync2[0] && !pitIrq && !twiMatchIrq && !cclIrq && sofIrq)
       |-> !wk.wakeReq;
   endproperty
   a_sof: assert property (p_sof) else $error("sof woke powerdown");
endmodule : smg_sleep_gate
`default_nettype wire

// ### sim/smg_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module smg_core_model (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic en,
   input wire logic [2:0] mode,
   input wire logic hll,
   output logic sleepInstr,
   output logic sleepEnableBit,
   output logic [2:0] sleepModeSelect,
   output logic hotLowLeakEnable
);
   logic armQ = 1'h0;
   initial begin
      sleepInstr = 1'h0;
      sleepEnableBit = 1'h0;
      sleepModeSelect = 3'h0;
      hotLowLeakEnable = 1'h0;
   end
   // Config lands a cycle ahead of the instruction pulse
   always @(posedge sys_clk) begin
      armQ <= go;
      sleepInstr <= #1 armQ;
      if (go) begin
         sleepEnableBit <= #1 en;
         sleepModeSelect <= #1 mode;
         // Leakage mode only with power-down, never standby
         hotLowLeakEnable <= #1 hll & (mode == 3'h2);
      end
   end
endmodule : smg_core_model
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "smg_cfg.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
 $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module testbench;
   int n_errors = 0;
   int n_checks = 0;
   logic sys_clk = 0, rst_n = 0, go = 0, en = 0, hll = 0, nvmBusy = 0;
   logic [2:0] mode = 0, sleepModeSelect, activeMode;
   logic sleepInstr, sleepEnableBit, hotLowLeakEnable;
   logic [`SMG_NPER+8:0] irq = 0;
   logic [1:0] fs = 0;
   logic ed = 0, mRs = 0, rRs = 0, cRs = 0;
   logic [`SMG_NPER-1:0] pRs = 0, perRun;
   logic cpuHalt, cpuResume, sleeping, nvmDisable, mainClkRun, rtcClkRun;
   logic rtcCounterRun, pitRun, cclClkRun, tcdClkRun, watchdogClkRun;
   logic brownoutClkRun, otherPerRun;
   always #2.5 sys_clk = ~sys_clk;
   smg_core_model u_core (.sys_clk, .go, .en, .mode, .hll, .sleepInstr,
      .sleepEnableBit, .sleepModeSelect, .hotLowLeakEnable);
   smg_sleep_gate u_dut (.sys_clk, .rst_n, .sleepModeSelect,
      .sleepEnableBit, .hotLowLeakEnable, .sleepInstr, .nvmBusy,
      .pinIrq(irq[0]), .vlmIrq(irq[1]), .mvioIrq(irq[2]), .pitIrq(irq[3]),
      .rtcCntIrq(irq[4]), .twiMatchIrq(irq[5]), .cclIrq(irq[6]),
      .cclFilterSelect(fs), .cclEdgeDetect(ed), .sofIrq(irq[7]),
      .perIrq(irq[`SMG_NPER+8:9]), .perRunStby(pRs), .otherIrq(irq[8]),
      .mainClkRunStby(mRs), .rtcRunStby(rRs), .cclRunStby(cRs), .cpuHalt,
      .cpuResume, .sleeping, .activeMode, .nvmDisable, .mainClkRun,
      .rtcClkRun, .rtcCounterRun, .pitRun, .cclClkRun, .tcdClkRun,
      .watchdogClkRun, .brownoutClkRun, .otherPerRun, .perRun);
   function automatic logic expWake(int s, logic [2:0] m, logic h);
      logic sb = (m == 3'h1);
      case (s)
         0, 1, 2, 3: return 1'h1;
         4: return (m == 3'h0) | (sb & rRs);
         5: return !((m == 3'h2) & h);
         6: return ((m == 3'h0) | (sb & cRs) | ((m == 3'h2) & !h)) &
            (fs == 2'h0) & !ed;
         7: return m != 3'h2;
         8: return m == 3'h0;
         default: return (m == 3'h0) | (sb & pRs[s-9]);
      endcase
   endfunction : expWake
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic req(logic [2:0] m, logic e, logic h);
      mode = m;
      en = e;
      hll = h;
      go = 1;
      cyc(1);
      go = 0;
   endtask : req
   task automatic chkRun(logic [2:0] m);
      logic i = (m == 3'h0);
      logic sb = (m == 3'h1);
      `CHK("mainClk", i | (sb & mRs), mainClkRun)
      `CHK("cclClk", i | (sb & cRs), cclClkRun)
      `CHK("rtcClk", i | (sb & rRs) | (m == 3'h2), rtcClkRun)
      `CHK("rtcCnt", i | (sb & rRs), rtcCounterRun)
      `CHK("pit", 1'h1, pitRun)
      `CHK("tcd", i, tcdClkRun)
      `CHK("other", i, otherPerRun)
      `CHK("per", i ? 8'hff : (sb ? pRs : 8'h00), perRun)
      `CHK("wdBo", 2'h3, {watchdogClkRun, brownoutClkRun})
      `CHK("mode", m, activeMode)
   endtask : chkRun
   task report_and_stop();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   initial begin
      #(5 * 30000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      int s, cnt;
      logic [2:0] m;
      logic h, w, lastRes;
      void'($urandom(32'h038e_d3dd));
      cyc(4);
      rst_n = 1;
      chkRun(3'h0);
      req(3'h1, 1'h0, 1'h0);
      cyc(4);
      `CHK("noEnable", 1'h0, cpuHalt)
      req(3'h3, 1'h1, 1'h0);
      cyc(4);
      `CHK("reserved", 1'h0, cpuHalt)
      for (int k = 0; k < 30; k++) begin
         // First pass walks every source once, then random
         m = (k < 17) ? 3'(k % 3) : 3'($urandom_range(2));
         s = (k < 17) ? k : $urandom_range(16);
         h = (m == 3'h2) & 1'($urandom);
         {fs, ed, mRs, rRs, cRs, pRs} = 14'($urandom);
         if (k[1])
            {fs, ed} = 3'h0;
         nvmBusy = k[0];
         req(m, 1'h1, h);
         cyc(3);
         `CHK("halt", 1'h1, cpuHalt & sleeping)
         cyc(2);
         `CHK("nvmHold", ~nvmBusy, nvmDisable)
         nvmBusy = 0;
         cyc(2);
         `CHK("nvmOff", 1'h1, nvmDisable)
         chkRun(m);
         w = expWake(s, m, h);
         irq[s] = 1;
         cnt = 0;
         lastRes = 0;
         while (cpuHalt === 1'h1 && cnt < 400) begin
            lastRes = cpuResume;
            cyc(1);
            cnt++;
            // Silent source: confirm sleep, then wake by the timer
            if (!w && cnt == 12) begin
               `CHK("noWake", 1'h1, sleeping)
               irq[3] = 1;
            end
         end
         if (w)
            `CHK("wakeCyc", 7 + ((s < 3) ? 2 : 0) + ((m != 3'h0) ?
               `SMG_STARTUP_CYCLES : 0), cnt)
         `CHK("resume", 1'h1, lastRes)
         irq = 0;
         cyc(2);
      end
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
